// ---- common/disc_ctrl_pkg.sv ----
// Package of constants, register map and carrier types for the head address and control decoder.
package disc_ctrl_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB bus).
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] fixed_addr_off = 12'h008;
  localparam logic [11:0] moving_addr_off = 12'h00c;
  localparam logic [11:0] fault_src_off = 12'h010;

  // ==========================================================================
  // Control register fields.
  localparam int ctrl_contig_bit = 0;
  localparam int ctrl_margin_a_bit = 1;
  localparam int ctrl_margin_b_bit = 2;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;

  // ==========================================================================
  // Unit addresses that allow margin mode on release.
  localparam logic [3:0] margin_unit_a = 4'hf;
  localparam logic [3:0] margin_unit_b = 4'h0;

  // ==========================================================================
  // Timing of the address mark logic.
  localparam logic [3:0] gap_preset = 4'h8;
  localparam int mark_pulse_ns = 9000;
  localparam int clk_period_ns = 10;
  localparam int mark_pulse_cycles = mark_pulse_ns / clk_period_ns;
  localparam logic [9:0] mark_pulse_count = 10'(mark_pulse_cycles);

  // ==========================================================================
  // Cable tag and bus carrier.
  typedef struct packed {
    logic tag1;
    logic tag2;
    logic tag3;
    logic [9:0] bus;
  } cable_cmd_t;

  // Per-unit status carrier.
  typedef struct packed {
    logic seek_error;
    logic on_track;
    logic wr_clock;
    logic wr_data;
  } unit_stat_t;

endpackage

// ---- hw/disc_head_addr_ctrl_decode.sv ----
// Head address latches, control function decoder, mark detector and unit fault latches.
//
// Our own choices: the placing of the registers and register access over APB.
module disc_head_addr_ctrl_decode
  import disc_ctrl_pkg::*;
(
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire cable_cmd_t cmd, // Tag and bus lines from the host.
  input wire logic [3:0] unit_addr, // Latched unit address.
  input wire logic moving_match, // Moving unit address comparator.
  input wire logic fixed_match, // Fixed unit address comparator.
  input wire logic cable_open, // Open cable condition.
  input wire logic service_jumper, // Maintenance jumper inserted.
  input wire logic [7:0] fixed_map, // Mapped fixed head address.
  input wire logic [1:0] map_bad, // Illegal bits from the address map.
  input wire logic drive_ready, // Drive ready from servo.
  input wire unit_stat_t moving_stat, // Moving unit status and write signals.
  input wire unit_stat_t fixed_stat, // Fixed unit status and write signals.
  input wire logic offset_allowed, // Track offset enable.
  input wire logic [7:0] moving_fault_src, // Moving unit gated fault sources.
  input wire logic [7:0] fixed_fault_src, // Fixed unit gated fault sources.
  input wire logic power_fault, // Power fault.
  input wire logic power_init, // Power-on initialize.
  input wire logic moving_cur_err, // Moving write current error.
  input wire logic fixed_cur_err, // Fixed write current error.
  input wire logic flux_pulse, // Detected flux change pulse.
  input wire logic bit_clock, // Bit clock level, sampled.
  output logic [7:0] fixed_head_addr, // Fixed head address latch.
  output logic bad_fixed_addr, // Illegal fixed head address.
  output logic [3:0] moving_head_addr, // Moving head address latch.
  output logic head_zero_hit, // Moving head zero addressed.
  output logic moving_unit_selected, // Moving unit selected.
  output logic fixed_unit_selected, // Fixed unit selected.
  output logic unit_sel_a, // Transmitter enable, moving unit.
  output logic unit_sel_b, // Transmitter enable, fixed unit.
  output logic write_request_a, // Write request one.
  output logic write_request_b, // Write request two.
  output logic write_active, // Write mode.
  output logic write_gate, // Write enable to data path.
  output logic write_mark_cmd, // Write address mark.
  output logic read_request, // Read request.
  output logic read_gate, // Read enable to data path.
  output logic offset_plus, // Servo offset plus.
  output logic offset_minus, // Servo offset minus.
  output logic track_offset, // Track offset to servo.
  output logic moving_fault_clear, // Moving fault clear.
  output logic fixed_fault_clear, // Fixed fault clear.
  output logic mark_control, // Address mark control.
  output logic mark_found_pulse, // Address mark found pulse.
  output logic moving_restore, // Moving restore.
  output logic fixed_restore, // Fixed restore.
  output logic servo_restore, // Restore command to servo.
  output logic window_early, // Data strobe early.
  output logic window_late, // Data strobe late.
  output logic release_cmd, // Release function.
  output logic margin_test, // Margin mode.
  output logic seek_error_out, // Multiplexed seek error.
  output logic unit_fault, // Multiplexed fault.
  output logic on_track_out, // Multiplexed on track.
  output logic wr_clock_out, // Multiplexed write clock.
  output logic wr_data_out, // Multiplexed write data.
  output logic unit_ok, // Unit ready.
  output logic moving_fault, // Moving fault latch.
  output logic fixed_fault // Fixed fault latch.
);

  // ==========================================================================
  // Internal state.
  logic [31:0] ctrl;
  logic tag1_q;
  logic tag2_q;
  logic fixed_strobe;
  logic moving_strobe;
  logic next_mov_sel;
  logic next_fix_sel;
  logic ena_m;
  logic ena_f;
  logic ena_any;
  logic next_wr_req;
  logic next_rd_req;
  logic next_mark;
  logic next_margin;
  logic next_wmode;
  logic next_fcl_m;
  logic next_fcl_f;
  logic next_detect;
  logic [3:0] gap_count;
  logic gap_found;
  logic bit_clock_q;
  logic flux_q;
  logic [9:0] pulse_count;
  logic bus_write;
  logic bus_read;

  // Selection decode and the per-unit control enables.
  always_comb begin
    next_mov_sel = moving_match && !cable_open && !service_jumper;
    next_fix_sel = fixed_match && !cable_open && !service_jumper;
    ena_m = cmd.tag3 && drive_ready && next_mov_sel;
    ena_f = cmd.tag3 && drive_ready && next_fix_sel;
    ena_any = ena_m || ena_f;
    next_wr_req = cmd.bus[0] && ena_any;
    next_rd_req = cmd.bus[1] && ena_any;
    next_mark = cmd.bus[5] && ena_any;
    next_margin = cmd.bus[9] && ena_any &&
                  ((unit_addr == margin_unit_a && ctrl[ctrl_margin_a_bit]) ||
                   (unit_addr == margin_unit_b && ctrl[ctrl_margin_b_bit]));
    next_fcl_m = cmd.bus[4] && ena_m;
    next_fcl_f = cmd.bus[4] && ena_f;
    next_wmode = next_wr_req && (next_margin ||
                 (unit_ok && next_mov_sel && !moving_stat.seek_error && !next_fcl_m) ||
                 (unit_ok && next_fix_sel && !fixed_stat.seek_error && !next_fcl_f));
    next_detect = next_mark && next_rd_req;
  end

  // Tag edges so that each tag assertion loads its latch once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag1_q <= 1'b0;
      tag2_q <= 1'b0;
    end else begin
      tag1_q <= cmd.tag1;
      tag2_q <= cmd.tag2;
    end
  end

  assign fixed_strobe = cmd.tag1 && !tag1_q && next_fix_sel;
  assign moving_strobe = cmd.tag2 && !tag2_q && next_mov_sel;

  // Head address latches and illegal fixed address flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_head_addr <= 8'h00;
      moving_head_addr <= 4'h0;
      head_zero_hit <= 1'b1;
      bad_fixed_addr <= 1'b0;
    end else begin
      if (fixed_restore) begin
        fixed_head_addr <= 8'h00;
      end else if (fixed_strobe) begin
        fixed_head_addr <= ctrl[ctrl_contig_bit] ? fixed_map : cmd.bus[7:0];
      end
      if (moving_restore) begin
        moving_head_addr <= 4'h0;
        head_zero_hit <= 1'b1;
      end else if (moving_strobe) begin
        moving_head_addr <= cmd.bus[3:0];
        head_zero_hit <= (cmd.bus[3:0] == 4'h0);
      end
      bad_fixed_addr <= ctrl[ctrl_contig_bit] && (&map_bad) && cmd.tag1 && next_fix_sel;
    end
  end

  // Registered control function outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving_unit_selected <= 1'b0;
      fixed_unit_selected <= 1'b0;
      unit_sel_a <= 1'b0;
      unit_sel_b <= 1'b0;
      write_request_a <= 1'b0;
      write_request_b <= 1'b0;
      write_active <= 1'b0;
      write_gate <= 1'b0;
      write_mark_cmd <= 1'b0;
      read_request <= 1'b0;
      read_gate <= 1'b0;
      offset_plus <= 1'b0;
      offset_minus <= 1'b0;
      track_offset <= 1'b0;
      moving_fault_clear <= 1'b0;
      fixed_fault_clear <= 1'b0;
      mark_control <= 1'b0;
      moving_restore <= 1'b0;
      fixed_restore <= 1'b0;
      servo_restore <= 1'b0;
      window_early <= 1'b0;
      window_late <= 1'b0;
      release_cmd <= 1'b0;
      margin_test <= 1'b0;
    end else begin
      moving_unit_selected <= next_mov_sel;
      fixed_unit_selected <= next_fix_sel;
      unit_sel_a <= ena_m;
      unit_sel_b <= ena_f;
      write_request_a <= next_wr_req;
      write_request_b <= next_wr_req;
      write_active <= next_wmode;
      write_gate <= next_wmode && !next_mark;
      write_mark_cmd <= next_wmode && next_mark;
      read_request <= next_rd_req;
      read_gate <= next_rd_req && !next_detect;
      offset_plus <= cmd.bus[2] && ena_any;
      offset_minus <= cmd.bus[3] && ena_any;
      track_offset <= (cmd.bus[2] || cmd.bus[3]) && ena_any &&
                      next_mov_sel && offset_allowed;
      moving_fault_clear <= next_fcl_m;
      fixed_fault_clear <= next_fcl_f;
      mark_control <= next_mark;
      moving_restore <= cmd.bus[6] && ena_m;
      fixed_restore <= cmd.bus[6] && ena_f;
      servo_restore <= cmd.bus[6] && ena_m;
      window_early <= cmd.bus[7] && ena_any;
      window_late <= cmd.bus[8] && ena_any;
      release_cmd <= cmd.bus[9] && ena_any;
      margin_test <= next_margin;
    end
  end

  // Gap counter: preset on flux, count down on each bit clock rise, latch gap at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_count <= gap_preset;
      gap_found <= 1'b0;
      bit_clock_q <= 1'b0;
      flux_q <= 1'b0;
    end else begin
      bit_clock_q <= bit_clock;
      flux_q <= flux_pulse;
      if (!next_detect) begin
        gap_count <= gap_preset;
        gap_found <= 1'b0;
      end else if (flux_pulse && !flux_q) begin
        gap_count <= gap_preset;
        gap_found <= 1'b0;
      end else if (bit_clock && !bit_clock_q && gap_count != 4'h0) begin
        gap_count <= gap_count - 4'h1;
      end else if (gap_count == 4'h0) begin
        gap_found <= 1'b1;
      end
    end
  end

  // Mark found one-shot fired by the first flux edge after a gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_count <= 10'h000;
      mark_found_pulse <= 1'b0;
    end else begin
      if (gap_found && next_detect && flux_pulse && !flux_q) begin
        pulse_count <= mark_pulse_count;
        mark_found_pulse <= 1'b1;
      end else if (pulse_count > 10'h001) begin
        pulse_count <= pulse_count - 10'h001;
      end else begin
        pulse_count <= 10'h000;
        mark_found_pulse <= 1'b0;
      end
    end
  end

  // Per-unit fault latches; a set wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving_fault <= 1'b0;
      fixed_fault <= 1'b0;
    end else begin
      if (power_fault || moving_cur_err || (next_mov_sel && |moving_fault_src)) begin
        moving_fault <= 1'b1;
      end else if (power_init || next_fcl_m) begin
        moving_fault <= 1'b0;
      end
      if (power_fault || fixed_cur_err || (next_fix_sel && |fixed_fault_src)) begin
        fixed_fault <= 1'b1;
      end else if (power_init || next_fcl_f) begin
        fixed_fault <= 1'b0;
      end
    end
  end

  // Status and write path multiplexing by the selected unit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seek_error_out <= 1'b0;
      unit_fault <= 1'b0;
      on_track_out <= 1'b0;
      wr_clock_out <= 1'b0;
      wr_data_out <= 1'b0;
      unit_ok <= 1'b0;
    end else begin
      seek_error_out <= next_fix_sel ? fixed_stat.seek_error : moving_stat.seek_error;
      unit_fault <= next_fix_sel ? fixed_fault : moving_fault;
      on_track_out <= next_fix_sel ? fixed_stat.on_track : moving_stat.on_track;
      wr_clock_out <= next_fix_sel ? fixed_stat.wr_clock : moving_stat.wr_clock;
      wr_data_out <= next_fix_sel ? fixed_stat.wr_data : moving_stat.wr_data;
      unit_ok <= drive_ready && !(next_fix_sel ? fixed_fault : moving_fault);
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped address.
  assign bus_write = psel && penable && pwrite;
  assign bus_read = psel && !penable && !pwrite;

  // Control register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_reset;
    end else if (bus_write && paddr == ctrl_off) begin
      ctrl <= {29'h0000_0000, pwdata[2:0]};
    end
  end

  // Read data is prepared in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == ctrl_off || paddr == status_off ||
                 paddr == fixed_addr_off || paddr == moving_addr_off ||
                 paddr == fault_src_off);
      if (bus_read) begin
        unique case (paddr)
          ctrl_off: prdata <= ctrl;
          status_off: prdata <= {22'h00_0000, margin_test, write_active, unit_ok,
                                 fixed_fault, moving_fault, bad_fixed_addr, head_zero_hit,
                                 fixed_unit_selected, moving_unit_selected, gap_found};
          fixed_addr_off: prdata <= {24'h00_0000, fixed_head_addr};
          moving_addr_off: prdata <= {28'h000_0000, moving_head_addr};
          fault_src_off: prdata <= {16'h0000, fixed_fault_src, moving_fault_src};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- bench/host_cable_model.sv ----
// Host controller model that drives the cable tag and bus lines.
module host_cable_model
  import disc_ctrl_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Reset, active low.
  input wire cable_cmd_t next_cmd, // Command the bench wants sent.
  output cable_cmd_t cmd // Tag and bus lines to the drive.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sends one level per cycle; with no tag up the bus carries no meaning, so it toggles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (next_cmd.tag1 || next_cmd.tag2 || next_cmd.tag3) begin
      cmd <= next_cmd;
    end else begin
      cmd <= {3'b000, ~cmd.bus};
    end
  end
endmodule

// ---- bench/disc_head_addr_ctrl_decode_properties.sv ----
// Checker of timing relations at the decoder's ports.
module disc_head_addr_ctrl_decode_chk
  import disc_ctrl_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire cable_cmd_t cmd, // Tags and bus.
  input wire logic drive_ready, // Drive ready.
  input wire logic moving_match, // Moving comparator.
  input wire logic cable_open, // Open cable.
  input wire logic service_jumper, // Jumper.
  input wire logic power_fault, // Power fault.
  input wire logic moving_cur_err, // Current error.
  input wire logic [7:0] moving_fault_src, // Fault sources.
  input wire logic moving_unit_selected, // Moving selected.
  input wire logic write_request_a, // Write request.
  input wire logic write_request_b, // Write request.
  input wire logic write_gate, // Write gate.
  input wire logic write_mark_cmd, // Mark write.
  input wire logic mark_control, // Mark control.
  input wire logic read_request, // Read request.
  input wire logic read_gate, // Read gate.
  input wire logic offset_plus, // Offset plus.
  input wire logic release_cmd, // Release.
  input wire logic moving_fault_clear, // Fault clear.
  input wire logic moving_fault, // Moving fault.
  input wire logic fixed_fault, // Fixed fault.
  input wire logic unit_ok, // Unit ready.
  input wire logic mark_found_pulse // Mark found.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic sel_in;
  logic en_ok;
  logic [9:0] run;
  // Selection, and the decode enable once selection has settled.
  assign sel_in = moving_match && !cable_open && !service_jumper;
  assign en_ok = cmd.tag3 && drive_ready && sel_in && moving_unit_selected;
  // Counts the cycles of the mark found pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
    end else begin
      run <= mark_found_pulse ? run + 10'h001 : 10'h000;
    end
  end
  // ==========================================================================
  // Assertions.
  a_moving_select: assert property (1'b1 |=> moving_unit_selected == $past(sel_in))
    else $error("moving select wrong");
  a_write_both: assert property (en_ok && cmd.bus[0] |=>
    write_request_a && write_request_b) else $error("write requests missing");
  a_no_decode: assert property (!cmd.tag3 |=> !write_request_a && !read_request &&
    !release_cmd && !mark_control) else $error("decode without tag");
  a_gate_no_mark: assert property (write_gate |-> !write_mark_cmd && !mark_control)
    else $error("write gate with mark");
  a_read_gate: assert property (en_ok && cmd.bus[1] |=>
    read_request && (read_gate != $past(cmd.bus[5]))) else $error("read gate wrong");
  a_offset_plus: assert property (en_ok && cmd.bus[2] |=> offset_plus)
    else $error("offset plus missing");
  a_release_cmd: assert property (en_ok && cmd.bus[9] |=> release_cmd)
    else $error("release missing");
  a_clear_fault: assert property (moving_fault_clear && !$past(power_fault) &&
    !$past(moving_cur_err) && $past(moving_fault_src) == 8'h00 |-> !moving_fault)
    else $error("fault not cleared");
  a_power_sets: assert property (power_fault |=> moving_fault && fixed_fault)
    else $error("power fault not latched");
  a_unit_ok: assert property (!drive_ready || (moving_fault && sel_in &&
    moving_unit_selected) |=> !unit_ok) else $error("unit ok wrong");
  a_pulse_len: assert property ($fell(mark_found_pulse) |-> run == mark_pulse_count)
    else $error("mark pulse length wrong");
endmodule

bind disc_head_addr_ctrl_decode disc_head_addr_ctrl_decode_chk u_disc_head_addr_ctrl_decode_chk
  (.*);

// ---- bench/disc_head_addr_ctrl_decode_tb.sv ----
// Self-checking bench of the head address and control decoder.
module disc_head_addr_ctrl_decode_tb
  import disc_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  cable_cmd_t want = '0, cmd, c;
  unit_stat_t moving_stat = '0, fixed_stat = '0, ms, fs, st;
  logic [3:0] unit_addr = '0, moving_head_addr, ua;
  logic [7:0] fixed_map = '0, moving_fault_src = '0, fixed_fault_src = '0, fixed_head_addr;
  logic [1:0] map_bad = '0;
  logic [9:0] b;
  logic moving_match = '0, fixed_match = '0, cable_open = '0, service_jumper = '0;
  logic drive_ready = '0, offset_allowed = '0, power_fault = '0, power_init = '0;
  logic moving_cur_err = '0, fixed_cur_err = '0, flux_pulse = '0, bit_clock = '0;
  logic u, rdy, oa, er, pready, pslverr, bad_fixed_addr, head_zero_hit, moving_unit_selected;
  logic fixed_unit_selected, unit_sel_a, unit_sel_b, write_request_a, write_request_b;
  logic write_active, write_gate, write_mark_cmd, read_request, read_gate, offset_plus;
  logic offset_minus, track_offset, moving_fault_clear, fixed_fault_clear, mark_control;
  logic mark_found_pulse, moving_restore, fixed_restore, servo_restore, window_early;
  logic window_late, release_cmd, margin_test, seek_error_out, unit_fault, on_track_out;
  logic wr_clock_out, wr_data_out, unit_ok, moving_fault, fixed_fault;
  int n_fail = 0, total_checks = 0, k, i, n;
  host_cable_model u_host_cable_model (.pclk(pclk), .presetn(presetn), .next_cmd(want), .cmd(cmd));
  disc_head_addr_ctrl_decode u_disc_head_addr_ctrl_decode (.*);
  // Clock at 100 MHz.
  always #5 pclk = ~pclk;
  // Compares one value and counts it.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick(input int m);
    repeat (m) @(posedge pclk);
  endtask
  // Hands a command to the host model and lets the outputs settle.
  task send(input cable_cmd_t v);
    @(posedge pclk);
    want <= v;
    tick(4);
    #1;
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      close_out();
    end
  endtask
  // Gives m one-cycle rises on flux pulse (fl high) or on bit clock.
  task edges(input logic fl, input int m);
    repeat (m) begin
      @(posedge pclk);
      flux_pulse <= fl;
      bit_clock <= !fl;
      @(posedge pclk);
      flux_pulse <= 1'b0;
      bit_clock <= 1'b0;
      tick(1);
    end
  endtask
  // Expected decode and multiplexer outputs for bus value v, control register all ones.
  function automatic logic [24:0] expect_dec(logic [9:0] v);
    logic en;
    logic mg;
    logic wa;
    en = rdy;
    mg = en & v[9] & (ua == margin_unit_a || ua == margin_unit_b);
    wa = en & v[0] & (mg | (!st.seek_error & !v[4]));
    return {en & !u, en & u, en & v[0], en & v[0], wa, wa & !v[5], wa & v[5], en & v[1],
      en & v[1] & !v[5], en & v[2], en & v[3], en & (v[2] | v[3]) & oa & !u, en & v[4] & !u,
      en & v[4] & u, en & v[5], en & v[6] & !u, en & v[7], en & v[8], en & v[9], mg, rdy, st};
  endfunction
  initial begin
    k = $urandom(25);
    tick(20);
    presetn <= 1'b1;
    // ==========================================================================
    // Registers.
    apb(1'b0, ctrl_off, 32'h0000_0000);
    chk("ctrl reset", ctrl_reset, rd);
    chk("head zero reset", 32'h0000_0001, 32'(head_zero_hit));
    apb(1'b1, ctrl_off, 32'h0000_0007);
    apb(1'b0, ctrl_off, 32'h0000_0000);
    chk("ctrl", 32'h0000_0007, rd & 32'h0000_0007);
    apb(1'b0, 12'hffc, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], er});
    $display("registers done");
    // ==========================================================================
    // Head address latches.
    @(posedge pclk);
    moving_match <= 1'b1;
    drive_ready <= 1'b1;
    b = 10'($urandom);
    c = '0;
    c.tag2 = 1'b1;
    c.bus = b;
    send(c);
    chk("moving latch", 32'(b[3:0]), 32'(moving_head_addr));
    chk("head zero", 32'(b[3:0] == 4'h0), 32'(head_zero_hit));
    c.bus = ~b;
    send(c);
    chk("moving once", 32'(b[3:0]), 32'(moving_head_addr));
    c = '0;
    c.tag3 = 1'b1;
    c.bus = 10'h040;
    send(c);
    chk("restore", 32'h0000_0030, {servo_restore, moving_restore, moving_head_addr});
    send('0);
    @(posedge pclk);
    moving_match <= 1'b0;
    fixed_match <= 1'b1;
    fixed_map <= b[7:0];
    map_bad <= 2'b11;
    c = '0;
    c.tag1 = 1'b1;
    send(c);
    chk("fixed latch", 32'({2'b11, b[7:0]}),
      32'({fixed_unit_selected, bad_fixed_addr, fixed_head_addr}));
    c = '0;
    c.tag3 = 1'b1;
    c.bus = 10'h040;
    send(c);
    chk("fixed clear", 32'h0000_0100, 32'({fixed_restore, fixed_head_addr}));
    $display("latches done");
    // ==========================================================================
    // Random control functions on either unit, with margin corner cases first.
    for (k = 0; k < 48; k++) begin
      u = 1'($urandom);
      rdy = ($urandom % 4) != 0;
      oa = 1'($urandom);
      ua = (k < 3) ? margin_unit_a : 4'($urandom);
      ms = unit_stat_t'(4'($urandom));
      fs = unit_stat_t'(4'($urandom));
      st = u ? fs : ms;
      b = 10'($urandom);
      if (k < 3) b = b | 10'h201;
      @(posedge pclk);
      moving_match <= !u;
      fixed_match <= u;
      drive_ready <= rdy;
      offset_allowed <= oa;
      unit_addr <= ua;
      moving_stat <= ms;
      fixed_stat <= fs;
      want <= '0;
      tick(3);
      c = '0;
      c.tag3 = 1'b1;
      c.bus = b;
      send(c);
      chk("decode", 32'(expect_dec(b)), 32'({unit_sel_a, unit_sel_b, write_request_a,
        write_request_b, write_active, write_gate, write_mark_cmd, read_request, read_gate,
        offset_plus, offset_minus, track_offset, moving_fault_clear, fixed_fault_clear,
        mark_control, servo_restore, window_early, window_late, release_cmd, margin_test,
        unit_ok, seek_error_out, on_track_out, wr_clock_out, wr_data_out}));
    end
    $display("decode done");
    // ==========================================================================
    // Fault latches.
    @(posedge pclk);
    moving_match <= 1'b1;
    fixed_match <= 1'b0;
    drive_ready <= 1'b1;
    want <= '0;
    moving_fault_src <= 8'h01 << ($urandom % 8);
    fixed_fault_src <= 8'hff;
    @(posedge pclk);
    moving_fault_src <= 8'h00;
    send('0);
    chk("fault set", 32'h0000_0006, {unit_ok, unit_fault, moving_fault, fixed_fault});
    c.bus = 10'h010;
    send(c);
    chk("fault clear", 32'h0000_0008, {unit_ok, unit_fault, moving_fault, fixed_fault});
    fixed_fault_src <= 8'h00;
    fixed_cur_err <= 1'b1;
    send('0);
    chk("current err", 32'h0000_0009, {unit_ok, unit_fault, moving_fault, fixed_fault});
    fixed_cur_err <= 1'b0;
    power_fault <= 1'b1;
    send('0);
    power_fault <= 1'b0;
    chk("power fault", 32'h0000_0007, {unit_ok, unit_fault, moving_fault, fixed_fault});
    power_init <= 1'b1;
    send('0);
    power_init <= 1'b0;
    chk("power init", 32'h0000_0000, {moving_fault, fixed_fault});
    $display("faults done");
    // ==========================================================================
    // Address mark detection: a short gap, then a full one.
    c.bus = 10'h022;
    send(c);
    edges(1'b1, 1);
    edges(1'b0, 6);
    edges(1'b1, 1);
    tick(4);
    #1;
    chk("short gap", 32'h0000_0000, 32'(mark_found_pulse));
    edges(1'b0, 8);
    apb(1'b0, status_off, 32'h0000_0000);
    chk("gap found", 32'h0000_0001, rd & 32'h0000_0001);
    flux_pulse <= 1'b1;
    for (n = 0; n < 8 && mark_found_pulse !== 1'b1; n++) begin
      @(posedge pclk);
      #1;
    end
    flux_pulse <= 1'b0;
    for (n = 1; n < 1000; n++) begin
      @(posedge pclk);
      #1;
      if (mark_found_pulse !== 1'b1) break;
    end
    chk("mark length", 32'(mark_pulse_count), 32'(n));
    $display("mark done");
    // ==========================================================================
    // Deselection by open cable and by the service jumper.
    cable_open <= 1'b1;
    send('0);
    chk("open cable", 32'h0000_0000, 32'(moving_unit_selected));
    cable_open <= 1'b0;
    service_jumper <= 1'b1;
    send('0);
    chk("jumper", 32'h0000_0000, 32'(moving_unit_selected));
    $display("select done");
    close_out();
  end
endmodule
